// ---- shared/second_analog_loop_cfg_pkg.sv ----
// constants, field layouts and carriers for the second analog loop config bank
// assumes a byte-wide register port with one-cycle strobes and one clock
package second_analog_loop_cfg_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam int          ADDR_W            = 16;
    localparam logic [15:0] OFF_CP_OVERRIDE   = 16'h1480;
    localparam logic [15:0] OFF_FB_MULT       = 16'h1481;
    localparam logic [15:0] OFF_LOOP_FILTER   = 16'h1482;
    localparam logic [15:0] OFF_OFFSET_CTRL   = 16'h1483;
    localparam logic [15:0] OFF_STATUS        = 16'h1484;
    localparam logic [15:0] OFF_EFFECTIVE_CP  = 16'h1485;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CP_OVERRIDE   = 8'h90;
    localparam logic [7:0]  RST_FB_MULT       = 8'h00;
    localparam logic [7:0]  RST_LOOP_FILTER   = 8'he0;
    localparam logic [7:0]  RST_OFFSET_CTRL   = 8'h03;
    localparam logic [7:0]  MASK_OFFSET_CTRL  = 8'h0f;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

    // ------------------------------------------------------------
    // analog scaling
    // ------------------------------------------------------------
    localparam logic [7:0]  FB_MULT_MIN       = 8'h0e;
    localparam int          CP_STEP_NA        = 3500;
    localparam int          ZERO_RES_STEP_OHM = 250;
    localparam int          POLE_CAP_BASE_PF  = 8;
    localparam int          POLE_CAP_STEP_PF  = 16;
    localparam logic [8:0]  POLE2_OHM_0       = 9'd200;
    localparam logic [8:0]  POLE2_OHM_1       = 9'd250;
    localparam logic [8:0]  POLE2_OHM_2       = 9'd333;
    localparam logic [8:0]  POLE2_OHM_3       = 9'd500;

    // ------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic       manual_en;
        logic [6:0] manual_code;
    } cp_override_t;

    typedef struct packed {
        logic [2:0] zero_resistor_select;
        logic [2:0] pole_capacitor_select;
        logic [1:0] second_pole_resistor_select;
    } loop_filter_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic       negative;
        logic [1:0] magnitude;
        logic       enable;
    } offset_ctrl_t;

    // decoded analog settings
    typedef struct packed {
        logic [18:0] cp_current_na;
        logic [10:0] zero_res_ohm;
        logic [6:0]  pole_cap_pf;
        logic [8:0]  second_pole_ohm;
        logic [17:0] offset_current_na;
        logic        offset_negative;
        logic        offset_enable;
    } analog_t;

endpackage

// ---- rtl/second_analog_loop_value_decode.sv ----
// turns the raw config codes into physical settings for the analog loop
// assumes inputs are register outputs of the same clock domain
`timescale 1ns/1ps
`default_nettype none
module second_analog_loop_value_decode (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       arst_n_i,
    // raw codes
    input  wire logic [6:0]                 cp_code_i,
    input  wire second_analog_loop_cfg_pkg::loop_filter_t lf_i,
    input  wire second_analog_loop_cfg_pkg::offset_ctrl_t off_i,
    // decoded settings
    output var  second_analog_loop_cfg_pkg::analog_t     analog_o
);
    import second_analog_loop_cfg_pkg::*;

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    function automatic logic [18:0] cp_na(input logic [6:0] code);
        cp_na = 19'(code * CP_STEP_NA);
    endfunction

    wire logic [18:0] cp_current = cp_na(cp_code_i);
    wire logic [10:0] zero_ohm   = 11'(lf_i.zero_resistor_select * ZERO_RES_STEP_OHM);
    wire logic [6:0]  cap_pf     = 7'(POLE_CAP_BASE_PF
                                   + lf_i.pole_capacitor_select * POLE_CAP_STEP_PF);
    // 00 halves, each step halves again
    // shift widened so code 11 still reaches one sixteenth
    wire logic [18:0] offset_na  = cp_current >> ({1'b0, off_i.magnitude} + 3'd1);
    wire logic [8:0]  pole2_ohm  = (lf_i.second_pole_resistor_select == 2'd0) ? POLE2_OHM_0 :
                                   (lf_i.second_pole_resistor_select == 2'd1) ? POLE2_OHM_1 :
                                   (lf_i.second_pole_resistor_select == 2'd2) ? POLE2_OHM_2 :
                                                                               POLE2_OHM_3;

    // ------------------------------------------------------------
    // output register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            analog_o <= '0;
        end else begin
            analog_o.cp_current_na     <= cp_current;
            analog_o.zero_res_ohm      <= zero_ohm;
            analog_o.pole_cap_pf       <= cap_pf;
            analog_o.second_pole_ohm   <= pole2_ohm;
            analog_o.offset_current_na <= off_i.enable ? offset_na[17:0] : 18'h00000;
            analog_o.offset_negative   <= off_i.negative;
            analog_o.offset_enable     <= off_i.enable;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/second_analog_loop_config_regs.sv ----
// register bank for the second analog loop: pump override, feedback
// multiplier, loop filter codes, offset_current_control
// assumes synchronous byte-wide register port; reads answer one cycle later
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module second_analog_loop_config_regs (
    // clock and reset
    input  wire logic                       CORE_CLK_I,
    input  wire logic                       ARST_N_I,
    // register port
    input  wire logic [15:0]                ADDR_I,
    input  wire logic [7:0]                 WDATA_I,
    input  wire logic                       WR_I,
    input  wire logic                       RD_I,
    output logic      [7:0]                 RDATA_O,
    // automatic pump control
    input  wire logic [6:0]                 CP_AUTO_CODE_I,
    // raw controls to the analog loop
    output logic                            CP_MANUAL_EN_O,
    output logic      [6:0]                 CP_CODE_O,
    output logic      [7:0]                 FEEDBACK_MULTIPLIER_O,
    output logic      [2:0]                 ZERO_RESISTOR_SELECT_O,
    output logic      [2:0]                 POLE_CAPACITOR_SELECT_O,
    output logic      [1:0]                 SECOND_POLE_RESISTOR_SELECT_O,
    output logic                            OFFSET_NEGATIVE_O,
    output logic      [1:0]                 OFFSET_MAGNITUDE_O,
    output logic                            OFFSET_ENABLE_O,
    output logic                            FB_MULT_RANGE_ERR_O,
    // decoded settings
    output var second_analog_loop_cfg_pkg::analog_t      ANALOG_O
);
    import second_analog_loop_cfg_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    wire logic wr_cp     = WR_I && hit(ADDR_I, OFF_CP_OVERRIDE);
    wire logic wr_fb     = WR_I && hit(ADDR_I, OFF_FB_MULT);
    wire logic wr_lf     = WR_I && hit(ADDR_I, OFF_LOOP_FILTER);
    wire logic wr_off    = WR_I && hit(ADDR_I, OFF_OFFSET_CTRL);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    cp_override_t cp_reg;
    logic [7:0]   fb_reg;
    loop_filter_t lf_reg;
    offset_ctrl_t off_reg;
    logic [6:0]   cp_auto;
    logic         fb_err;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cp_reg <= cp_override_t'(RST_CP_OVERRIDE);
        end else if (wr_cp) begin
            cp_reg <= cp_override_t'(WDATA_I);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fb_reg <= RST_FB_MULT;
        end else if (wr_fb) begin
            fb_reg <= WDATA_I;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lf_reg <= loop_filter_t'(RST_LOOP_FILTER);
        end else if (wr_lf) begin
            lf_reg <= loop_filter_t'(WDATA_I);
        end
    end

    // reserved upper nibble never stored
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            off_reg <= offset_ctrl_t'(RST_OFFSET_CTRL);
        end else if (wr_off) begin
            off_reg <= offset_ctrl_t'(WDATA_I & MASK_OFFSET_CTRL);
        end
    end

    // ------------------------------------------------------------
    // pump source selection
    // ------------------------------------------------------------
    // automatic code registered so output stays flop-driven
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cp_auto <= 7'h00;
        end else begin
            cp_auto <= CP_AUTO_CODE_I;
        end
    end

    // manual code only counts while enable is set
    wire logic [6:0] next_cp_code = cp_reg.manual_en ? cp_reg.manual_code
                                                     : cp_auto;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CP_CODE_O <= 7'h00;
        end else begin
            CP_CODE_O <= next_cp_code;
        end
    end

    // ------------------------------------------------------------
    // multiplier range watch
    // ------------------------------------------------------------
    // hardware does not clamp; software owns the range, this only reports
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fb_err <= 1'b0;
        end else begin
            fb_err <= (fb_reg < FB_MULT_MIN);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire logic [7:0] status_word = {5'h00, off_reg.enable, cp_reg.manual_en, fb_err};
    wire logic [7:0] read_mux =
        hit(ADDR_I, OFF_CP_OVERRIDE)  ? cp_reg :
        hit(ADDR_I, OFF_FB_MULT)      ? fb_reg :
        hit(ADDR_I, OFF_LOOP_FILTER)  ? lf_reg :
        hit(ADDR_I, OFF_OFFSET_CTRL)  ? (off_reg & MASK_OFFSET_CTRL) :
        hit(ADDR_I, OFF_STATUS)       ? status_word :
        hit(ADDR_I, OFF_EFFECTIVE_CP) ? {1'b0, CP_CODE_O} :
                                        READ_UNMAPPED;

    // answer stands only in the cycle after the strobe
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            RDATA_O <= read_mux;
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // raw control outputs
    // ------------------------------------------------------------
    assign CP_MANUAL_EN_O                = cp_reg.manual_en;
    assign FEEDBACK_MULTIPLIER_O         = fb_reg;
    assign ZERO_RESISTOR_SELECT_O        = lf_reg.zero_resistor_select;
    assign POLE_CAPACITOR_SELECT_O       = lf_reg.pole_capacitor_select;
    assign SECOND_POLE_RESISTOR_SELECT_O = lf_reg.second_pole_resistor_select;
    assign OFFSET_NEGATIVE_O             = off_reg.negative;
    assign OFFSET_MAGNITUDE_O            = off_reg.magnitude;
    assign OFFSET_ENABLE_O               = off_reg.enable;
    assign FB_MULT_RANGE_ERR_O           = fb_err;

    // ------------------------------------------------------------
    // physical value decode
    // ------------------------------------------------------------
    second_analog_loop_value_decode u_decode (
        .clk_i     (CORE_CLK_I),
        .arst_n_i  (ARST_N_I),
        .cp_code_i (CP_CODE_O),
        .lf_i      (lf_reg),
        .off_i     (off_reg),
        .analog_o  (ANALOG_O)
    );
endmodule
`default_nettype wire

// ---- testbench/second_analog_loop_config_regs_assertions.sv ----
// port checker for the second analog loop config bank
// assumes one clock domain, async active-low reset, bound in below
`timescale 1ns/1ps
`default_nettype none
module second_analog_loop_config_regs_assertions (
    // clock and reset
    input wire logic                   CORE_CLK_I,
    input wire logic                   ARST_N_I,
    // register port
    input wire logic [15:0]            ADDR_I,
    input wire logic [7:0]             WDATA_I,
    input wire logic                   WR_I,
    input wire logic                   RD_I,
    input wire logic [7:0]             RDATA_O,
    // loop controls
    input wire logic [6:0]             CP_AUTO_CODE_I,
    input wire logic                   CP_MANUAL_EN_O,
    input wire logic [6:0]             CP_CODE_O,
    input wire logic [7:0]             FEEDBACK_MULTIPLIER_O,
    input wire logic [1:0]             OFFSET_MAGNITUDE_O,
    input wire logic                   FB_MULT_RANGE_ERR_O,
    input wire second_analog_loop_cfg_pkg::analog_t ANALOG_O
);
    import second_analog_loop_cfg_pkg::*;
    logic [6:0] man_code;
    logic [1:0] age;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // mirror of the manual code, which no port shows
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            man_code <= 7'h10;
            age      <= 2'h0;
        end else begin
            if (WR_I && ADDR_I == OFF_CP_OVERRIDE) man_code <= WDATA_I[6:0];
            if (age != 2'h3) age <= age + 2'h1;
        end
    end
    property p_rd_fb; RD_I && ADDR_I == OFF_FB_MULT |=> RDATA_O == $past(FEEDBACK_MULTIPLIER_O);
    endproperty
    a_rd_fb: assert property (p_rd_fb) else $error("readback wrong");
    property p_rd_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rsvd; RD_I && ADDR_I == OFF_OFFSET_CTRL |=> RDATA_O[7:4] == 4'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_en; WR_I && ADDR_I == OFF_CP_OVERRIDE |=> CP_MANUAL_EN_O == $past(WDATA_I[7]);
    endproperty
    a_en: assert property (p_en) else $error("manual enable wrong");
    property p_man; CP_MANUAL_EN_O |=> CP_CODE_O == $past(man_code); endproperty
    a_man: assert property (p_man) else $error("manual code not used");
    property p_auto; !CP_MANUAL_EN_O |=> CP_CODE_O == $past(CP_AUTO_CODE_I, 2); endproperty
    a_auto: assert property (p_auto) else $error("auto code not used");
    property p_range; age == 2'h3 |-> FB_MULT_RANGE_ERR_O == ($past(FEEDBACK_MULTIPLIER_O) < 8'h0e);
    endproperty
    a_range: assert property (p_range) else $error("range flag wrong");
    property p_cur; age == 2'h3 |-> ANALOG_O.cp_current_na == 19'($past(CP_CODE_O)) * 19'd3500;
    endproperty
    a_cur: assert property (p_cur) else $error("pump current wrong");
    // shift widened so that code 11 still divides by sixteen
    property p_dc; age == 2'h3 |-> ANALOG_O.offset_current_na == (ANALOG_O.offset_enable ?
        18'(ANALOG_O.cp_current_na >> ({1'b0, $past(OFFSET_MAGNITUDE_O)} + 3'h1)) : 18'h0);
    endproperty
    a_dc: assert property (p_dc) else $error("offset current wrong");
endmodule
bind second_analog_loop_config_regs second_analog_loop_config_regs_assertions i_second_analog_loop_config_regs_assertions (
    .CORE_CLK_I, .ARST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .CP_AUTO_CODE_I,
    .CP_MANUAL_EN_O, .CP_CODE_O, .FEEDBACK_MULTIPLIER_O, .OFFSET_MAGNITUDE_O,
    .FB_MULT_RANGE_ERR_O, .ANALOG_O);
`default_nettype wire

// ---- testbench/second_analog_loop_config_regs_tb.sv ----
// self-checking bench for the second analog loop config bank
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
`default_nettype none
module second_analog_loop_config_regs_tb;
    import second_analog_loop_cfg_pkg::*;
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic [15:0] addr     = 16'h0000;
    logic [7:0]  wdata    = 8'h00;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [6:0]  cp_auto  = 7'h00;
    logic [7:0]  rdata, fb_mult, d;
    logic [6:0]  cp_code;
    logic [2:0]  zr, pc;
    logic [1:0]  sp, off_mag;
    logic        cp_en, off_neg, off_en, fb_err;
    analog_t     analog, exp;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [7:0]  rst_vals [4] = '{8'h90, 8'h00, 8'he0, 8'h03};
    logic [8:0]  pole2 [4] = '{9'd200, 9'd250, 9'd333, 9'd500};
    // address, write data, expected readback
    logic [31:0] rows [7] = '{32'h14807f7f, 32'h14808585, 32'h14810e0e, 32'h1481ffff,
                              32'h14821515, 32'h1483ff0f, 32'h1490aa00};
    second_analog_loop_config_regs i_second_analog_loop_config_regs (
        .CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CP_AUTO_CODE_I(cp_auto),
        .CP_MANUAL_EN_O(cp_en), .CP_CODE_O(cp_code), .FEEDBACK_MULTIPLIER_O(fb_mult),
        .ZERO_RESISTOR_SELECT_O(zr), .POLE_CAPACITOR_SELECT_O(pc),
        .SECOND_POLE_RESISTOR_SELECT_O(sp), .OFFSET_NEGATIVE_O(off_neg),
        .OFFSET_MAGNITUDE_O(off_mag), .OFFSET_ENABLE_O(off_en),
        .FB_MULT_RANGE_ERR_O(fb_err), .ANALOG_O(analog));
    always #2 core_clk = ~core_clk;
    // the run needs about 120 cycles; a hang is cut well after
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    task automatic check_data(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            fails++;
            $display("mismatch t=%0t got=%0h exp=%0h", $time, got, want);
        end
    endtask
    task automatic check_out(input logic [65:0] got, input logic [65:0] want);
        checks++;
        if (got !== want) begin
            fails++;
            $display("mismatch t=%0t got=%0h exp=%0h", $time, got, want);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        foreach (rst_vals[i]) begin
            rd_reg(16'h1480 + 16'(i), d);
            check_data(d, rst_vals[i]);
        end
        check_out(66'(cp_code), 66'h10);
        $display("reset test done");
        foreach (rows[i]) begin
            wr_reg(rows[i][31:16], rows[i][15:8]);
            rd_reg(rows[i][31:16], d);
            check_data(d, rows[i][7:0]);
        end
        $display("table test done");
        // code written without the enable must not reach the pump
        @(posedge core_clk) cp_auto <= 7'h2a;
        wr_reg(OFF_CP_OVERRIDE, 8'h05);
        repeat (2) @(posedge core_clk);
        #1 check_out(66'(cp_code), 66'h2a);
        wr_reg(OFF_CP_OVERRIDE, 8'hff);
        repeat (2) @(posedge core_clk);
        #1 check_out(66'(cp_code), 66'h7f);
        check_out(66'(cp_en), 66'h1);
        rd_reg(OFF_EFFECTIVE_CP, d);
        check_data(d, 8'h7f);
        wr_reg(OFF_FB_MULT, 8'h0d);
        repeat (2) @(posedge core_clk);
        #1 check_out(66'(fb_err), 66'h1);
        rd_reg(OFF_STATUS, d);
        check_data(d, 8'h07);
        wr_reg(OFF_FB_MULT, 8'h0e);
        repeat (2) @(posedge core_clk);
        #1 check_out(66'(fb_err), 66'h0);
        check_out(66'(fb_mult), 66'h0e);
        $display("pump and range test done");
        // every filter code and offset magnitude, sign and enable mixed
        for (int k = 0; k < 8; k++) begin
            wr_reg(OFF_LOOP_FILTER, {k[2:0], k[2:0], k[1:0]});
            wr_reg(OFF_OFFSET_CTRL, {4'h0, k[0], k[1:0], k[2]});
            repeat (3) @(posedge core_clk);
            exp = '{19'd444500, 11'(250 * k), 7'(8 + 16 * k), pole2[k[1:0]],
                    k[2] ? 18'(444500 >> (k[1:0] + 1)) : 18'h0, k[0], k[2]};
            #1 check_out(analog, exp);
            check_out(66'({zr, pc, sp, off_neg, off_mag, off_en}),
                      66'({k[2:0], k[2:0], k[1:0], k[0], k[1:0], k[2]}));
        end
        $display("decode test done");
        complete_run();
    end
endmodule
`default_nettype wire
